// ### logic/pli_pkg.sv
// shared constants and types of the parallel line controller
package pli_pkg;

   localparam int          LINE_COUNT = 32;
   localparam int          ADDR_WIDTH = 12;

   // register offsets, byte addresses
   localparam logic [11:0] OFF_OWN_EN   = 12'h000;
   localparam logic [11:0] OFF_OWN_DIS  = 12'h004;
   localparam logic [11:0] OFF_OWN_STAT = 12'h008;
   localparam logic [11:0] OFF_OE_EN    = 12'h010;
   localparam logic [11:0] OFF_OE_DIS   = 12'h014;
   localparam logic [11:0] OFF_OE_STAT  = 12'h018;
   localparam logic [11:0] OFF_FLT_EN   = 12'h020;
   localparam logic [11:0] OFF_FLT_DIS  = 12'h024;
   localparam logic [11:0] OFF_FLT_STAT = 12'h028;
   localparam logic [11:0] OFF_LVL_SET  = 12'h030;
   localparam logic [11:0] OFF_LVL_CLR  = 12'h034;
   localparam logic [11:0] OFF_LVL_STAT = 12'h038;
   localparam logic [11:0] OFF_PAD_RB   = 12'h03c;
   localparam logic [11:0] OFF_IRQ_EN   = 12'h040;
   localparam logic [11:0] OFF_IRQ_DIS  = 12'h044;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h048;
   localparam logic [11:0] OFF_IRQ_PEND = 12'h04c;
   localparam logic [11:0] OFF_OD_EN    = 12'h050;
   localparam logic [11:0] OFF_OD_DIS   = 12'h054;
   localparam logic [11:0] OFF_OD_STAT  = 12'h058;
   localparam logic [11:0] OFF_PU_DIS   = 12'h060;
   localparam logic [11:0] OFF_PU_EN    = 12'h064;
   localparam logic [11:0] OFF_PU_STAT  = 12'h068;
   localparam logic [11:0] OFF_SEL_A    = 12'h070;
   localparam logic [11:0] OFF_SEL_B    = 12'h074;
   localparam logic [11:0] OFF_SEL_STAT = 12'h078;
   localparam logic [11:0] OFF_DW_EN    = 12'h0a0;
   localparam logic [11:0] OFF_DW_DIS   = 12'h0a4;
   localparam logic [11:0] OFF_DW_STAT  = 12'h0a8;

   // product build: implemented lines, lines with a peripheral, ownership at reset
   localparam logic [31:0] LINE_IMPL_MASK  = 32'hffffffff;
   localparam logic [31:0] LINE_MUXED_MASK = 32'hffffffff;
   localparam logic [31:0] OWN_RESET       = 32'h00000000;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pli_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } pli_apb_rsp_type;

   typedef struct packed {
      logic [31:0] a_out;
      logic [31:0] a_oe;
      logic [31:0] b_out;
      logic [31:0] b_oe;
   } pli_periph_type;

   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
      logic [31:0] pullup_on;
   } pli_pad_drive_type;

   typedef struct packed {
      logic [31:0]       own;
      logic [31:0]       oe;
      logic [31:0]       filt;
      logic [31:0]       level;
      logic [31:0]       mask;
      logic [31:0]       pend;
      logic [31:0]       od;
      logic [31:0]       pu_off;
      logic [31:0]       sel_b;
      logic [31:0]       dw;
      logic [31:0]       s1;
      logic [31:0]       s2;
      logic [31:0]       s3;
      logic [31:0]       pin;
      logic [31:0]       pin_q;
      logic [31:0]       filt_val;
      logic [31:0]       prev_rb;
      logic [31:0]       prdata;
      logic              irq;
      pli_pad_drive_type drv;
   } pli_state_type;

   localparam pli_state_type STATE_RESET = '{own: OWN_RESET, drv: '0, default: '0};

endpackage

// ### logic/pli_ctrl.sv
// register interface and pad logic of the 32-line parallel controller
//
// How it works
// - every register is 32 bits, bit n belongs to line n
// - writes to bits of unimplemented lines change nothing
// - bits of unimplemented lines always read zero
// - lines without a peripheral always read owned by the controller
// - ones written at 0x0000 give the line to the controller
// - ones written at 0x0004 give the line to the peripheral
// - ownership reset value is a per-line build constant
// - direct level writes at 0x0038 only touch authorised bits
// - pad readback shows the real line levels, no fixed reset value
// - pending changes reset to zero but may latch right after reset
// - 0x0070 ones select peripheral A, 0x0074 ones select B
// - output drive set at 0x0010, cleared at 0x0014, status resets zero
// - glitch filter set at 0x0020, cleared at 0x0024, status resets zero
// - output level set at 0x0030, cleared at 0x0034, resets zero
// - change interrupt enable set 0x0040, cleared 0x0044, mask resets zero
// - open drain set at 0x0050, cleared at 0x0054, status resets zero
// - pull-up disable 0x0060, enable 0x0064, status resets zero
// - direct write grant 0x00a0, revoke 0x00a4, status resets zero
// - reading pending changes clears the bits that read returned
// - a line change sets its pending bit; masked pending raises the interrupt
// - all line interrupt conditions are ored into one request
`timescale 1ns/10ps

module pli_ctrl (
   input  wire logic                       i_clock,
   input  wire logic                       i_rst_b,
   input  wire pli_pkg::pli_apb_req_type   i_apb,
   output      pli_pkg::pli_apb_rsp_type   o_apb,
   input  wire logic [31:0]                i_pad_in,
   input  wire pli_pkg::pli_periph_type    i_periph,
   output      pli_pkg::pli_pad_drive_type o_pad,
   output      logic [31:0]                o_periph_owned,
   output      logic [31:0]                o_sel_b,
   output      logic                       o_irq
);
   import pli_pkg::*;

   pli_state_type r;
   pli_state_type next_r;

   // bitwise set then clear, implemented lines only
   function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] s,
                                           input logic [31:0] c);
      set_clr = ((cur | s) & ~c) & LINE_IMPL_MASK;
   endfunction

   // write strobe of one offset, gated by the data lanes of implemented lines
   function automatic logic [31:0] wr_hit(input pli_apb_req_type b, input logic [11:0] off);
      wr_hit = (b.psel && b.penable && b.pwrite && b.paddr == off) ? (b.pwdata & LINE_IMPL_MASK) : 32'h00000000;
   endfunction

   logic [31:0] rb;
   logic [31:0] own_view;
   logic [31:0] agree;
   logic [31:0] stable;
   logic [31:0] change;
   logic [31:0] rd_clr;
   logic [31:0] rd_val;
   logic [31:0] ctl_out;
   logic [31:0] ctl_oe;
   logic [31:0] mux_out;
   logic [31:0] mux_oe;
   logic        setup_rd;
   logic        access_rd;

   // line ownership as software sees it, non-muxed lines stuck at controller
   assign own_view  = (r.own | ~LINE_MUXED_MASK) & LINE_IMPL_MASK;
   // filtered or raw pad level, depending on the per-line filter enable
   assign rb        = ((r.filt & r.filt_val) | (~r.filt & r.pin)) & LINE_IMPL_MASK;
   assign setup_rd  = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
   assign access_rd = i_apb.psel && i_apb.penable && !i_apb.pwrite;

   // read multiplexer, sampled in the setup phase so data sits in a flop
   always_comb begin
      unique case (i_apb.paddr)
         OFF_OWN_STAT: rd_val = own_view;
         OFF_OE_STAT:  rd_val = r.oe;
         OFF_FLT_STAT: rd_val = r.filt;
         OFF_LVL_STAT: rd_val = r.level;
         OFF_PAD_RB:   rd_val = rb;
         OFF_IRQ_MASK: rd_val = r.mask;
         OFF_IRQ_PEND: rd_val = r.pend;
         OFF_OD_STAT:  rd_val = r.od;
         OFF_PU_STAT:  rd_val = r.pu_off;
         OFF_SEL_STAT: rd_val = r.sel_b;
         OFF_DW_STAT:  rd_val = r.dw;
         default:      rd_val = 32'h00000000;
      endcase
   end

   // pad drive: controller or selected peripheral, then open-drain shaping
   always_comb begin
      ctl_out = r.level;
      ctl_oe  = r.oe;
      mux_out = (own_view & ctl_out) | (~own_view & ((r.sel_b & i_periph.b_out) | (~r.sel_b & i_periph.a_out)));
      mux_oe  = (own_view & ctl_oe) | (~own_view & ((r.sel_b & i_periph.b_oe) | (~r.sel_b & i_periph.a_oe)));
   end

   // input sampling: a change counts once the second and third stages agree
   assign agree  = ~(r.s2 ^ r.s3);
   // glitch filter accepts a level only after two equal samples
   assign stable = ~(r.pin ^ r.pin_q);
   assign change = (rb ^ r.prev_rb) & LINE_IMPL_MASK;
   // clear only what the read actually returned, so a change in flight survives
   assign rd_clr = (access_rd && i_apb.paddr == OFF_IRQ_PEND) ? r.prdata : 32'h00000000;

   always_comb begin
      next_r          = r;
      next_r.s1       = i_pad_in;
      next_r.s2       = r.s1;
      next_r.s3       = r.s2;
      next_r.pin      = (r.pin & ~agree) | (r.s2 & agree);
      next_r.pin_q    = r.pin;
      next_r.filt_val = (r.filt_val & ~stable) | (r.pin & stable);
      next_r.prev_rb  = rb;

      // paired set/clear control registers
      next_r.own    = set_clr(r.own, wr_hit(i_apb, OFF_OWN_EN), wr_hit(i_apb, OFF_OWN_DIS));
      next_r.oe     = set_clr(r.oe, wr_hit(i_apb, OFF_OE_EN), wr_hit(i_apb, OFF_OE_DIS));
      next_r.filt   = set_clr(r.filt, wr_hit(i_apb, OFF_FLT_EN), wr_hit(i_apb, OFF_FLT_DIS));
      next_r.mask   = set_clr(r.mask, wr_hit(i_apb, OFF_IRQ_EN), wr_hit(i_apb, OFF_IRQ_DIS));
      next_r.od     = set_clr(r.od, wr_hit(i_apb, OFF_OD_EN), wr_hit(i_apb, OFF_OD_DIS));
      next_r.pu_off = set_clr(r.pu_off, wr_hit(i_apb, OFF_PU_DIS), wr_hit(i_apb, OFF_PU_EN));
      next_r.sel_b  = set_clr(r.sel_b, wr_hit(i_apb, OFF_SEL_B), wr_hit(i_apb, OFF_SEL_A));
      next_r.dw     = set_clr(r.dw, wr_hit(i_apb, OFF_DW_EN), wr_hit(i_apb, OFF_DW_DIS));

      // output level: set/clear, plus direct write on authorised lines
      next_r.level = set_clr(r.level, wr_hit(i_apb, OFF_LVL_SET), wr_hit(i_apb, OFF_LVL_CLR));
      if (i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.paddr == OFF_LVL_STAT) begin
         next_r.level = ((r.level & ~r.dw) | (i_apb.pwdata & r.dw)) & LINE_IMPL_MASK;
      end

      // set wins over the read clear
      next_r.pend = ((r.pend & ~rd_clr) | change) & LINE_IMPL_MASK;
      next_r.irq  = |(r.pend & r.mask);

      if (setup_rd) begin
         next_r.prdata = rd_val & LINE_IMPL_MASK;
      end

      // open drain lines only ever pull low
      next_r.drv.out       = mux_out & ~r.od & LINE_IMPL_MASK;
      next_r.drv.oe        = ((mux_oe & ~r.od) | (mux_oe & r.od & ~mux_out)) & LINE_IMPL_MASK;
      next_r.drv.pullup_on = ~r.pu_off & LINE_IMPL_MASK;
   end

   // single state register, synchronous reset
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         r <= STATE_RESET;
      end else begin
         r <= next_r;
      end
   end

   // zero wait states, no errors on this bus
   assign o_apb          = '{prdata: r.prdata, pready: 1'b1, pslverr: 1'b0};
   assign o_pad          = r.drv;
   assign o_periph_owned = ~own_view & LINE_IMPL_MASK;
   assign o_sel_b        = r.sel_b;
   assign o_irq          = r.irq;

endmodule // pli_ctrl

// ### test/pli_props.sv
// port checker of the parallel line controller
`timescale 1ns/10ps
module pli_props (
   input wire logic                       i_clock,
   input wire logic                       i_rst_b,
   input wire pli_pkg::pli_apb_req_type   i_apb,
   input wire pli_pkg::pli_apb_rsp_type   o_apb,
   input wire pli_pkg::pli_pad_drive_type o_pad,
   input wire logic [31:0]                o_periph_owned,
   input wire logic [31:0]                o_sel_b,
   input wire logic                       o_irq
);
   import pli_pkg::*;
   logic [31:0] wd;
   // data of the last write; held until the next write lands
   always_ff @(posedge i_clock) begin
      if (i_apb.psel && i_apb.penable && i_apb.pwrite) wd <= i_apb.pwdata;
   end
   sequence s_wr(logic [11:0] a);
      i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.paddr == a;
   endsequence
   sequence s_rd(logic [11:0] a);
      i_apb.psel && !i_apb.penable && !i_apb.pwrite && i_apb.paddr == a;
   endsequence
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   a_own_give: assert property (s_wr(OFF_OWN_DIS) |=> (o_periph_owned & wd) == wd)
      else $error("line not handed over");
   a_own_take: assert property (s_wr(OFF_OWN_EN) |=> (o_periph_owned & wd) == 0)
      else $error("line not taken back");
   a_sel_second: assert property (s_wr(OFF_SEL_B) |=> (o_sel_b & wd) == wd)
      else $error("second function not chosen");
   a_sel_first: assert property (s_wr(OFF_SEL_A) |=> (o_sel_b & wd) == 0)
      else $error("first function not chosen");
   a_pullup_off: assert property (s_wr(OFF_PU_DIS) |=> ##1 (o_pad.pullup_on & wd) == 0)
      else $error("pull-up still on");
   a_rsv_zero: assert property (s_rd(12'h00c) |=> o_apb.prdata == 0)
      else $error("reserved read not zero");
   a_wo_zero: assert property (s_rd(OFF_OE_EN) |=> o_apb.prdata == 0)
      else $error("write-only read not zero");
   a_oe_reset: assert property (disable iff (1'b0) !i_rst_b |=> o_pad.oe == 0)
      else $error("drive on after reset");
   a_irq_reset: assert property (disable iff (1'b0) !i_rst_b |=> !o_irq)
      else $error("interrupt after reset");
endmodule // pli_props

bind pli_ctrl pli_props chk_u (.i_clock, .i_rst_b, .i_apb, .o_apb, .o_pad, .o_periph_owned, .o_sel_b, .o_irq);

// ### test/pli_pad_model.sv
// pad model on the far side of the controller
`timescale 1ns/10ps
module pli_pad_model (
   input  wire logic                       i_clock,
   input  wire pli_pkg::pli_pad_drive_type i_drive,
   input  wire logic [31:0]                i_ext,
   input  wire logic [31:0]                i_ext_en,
   output      logic [31:0]                o_level
);
   import pli_pkg::*;
   logic [31:0] last;
   // drive wins, then outside source, then pull-up; a floating line flips so no value is trusted
   assign o_level = (i_drive.oe & i_drive.out) | (~i_drive.oe & i_ext_en & i_ext)
                  | (~i_drive.oe & ~i_ext_en & (i_drive.pullup_on | ~last));
   always_ff @(posedge i_clock) last <= o_level;
endmodule // pli_pad_model

// ### test/testbench.sv
// self-checking bench of the parallel line controller
`timescale 1ns/10ps
module testbench;
   import pli_pkg::*;
   logic              i_clock = 0;
   logic              i_rst_b = 0;
   pli_apb_req_type   i_apb = '0;
   pli_apb_rsp_type   o_apb;
   pli_periph_type    i_periph = '0;
   pli_pad_drive_type o_pad;
   logic [31:0]       pad, owned, selb, d1, d2, sb, stat [9];
   logic [31:0]       ext = '0, ext_en = '1;
   logic              o_irq;
   int                miscompares = 0, comparisons = 0, cycles = 0;
   logic [31:0]       exp_q [$], care_q [$];
   string             name_q [$];
   pli_ctrl dut_u (.i_clock, .i_rst_b, .i_apb, .o_apb, .i_pad_in(pad), .i_periph, .o_pad,
                   .o_periph_owned(owned), .o_sel_b(selb), .o_irq);
   pli_pad_model pad_u (.i_clock, .i_drive(o_pad), .i_ext(ext), .i_ext_en(ext_en), .o_level(pad));
   initial forever #10 i_clock = ~i_clock;
   // group k: s 0 sets, 1 clears, 2 status; the peripheral pair is swapped
   function automatic logic [11:0] addr(int k, int s);
      return (k < 8 ? 12'(k * 16) : 12'h0a0) + 12'((k == 7 && s < 2) ? 4 - 4 * s : 4 * s);
   endfunction
   function automatic logic [31:0] st(int k);
      return (k == 0 ? stat[k] | ~LINE_MUXED_MASK : stat[k]) & LINE_IMPL_MASK;
   endfunction
   task automatic check(input string n, input logic [31:0] e, s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clock) #1 i_apb = '{1'b1, 1'b0, w, a, d};
      @(posedge i_clock) #1 i_apb.penable = 1'b1;
      @(posedge i_clock) #1 i_apb = '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, c, input string n);
      exp_q.push_back(e & c);
      care_q.push_back(c);
      name_q.push_back(n);
      bus(1'b0, a, '0);
   endtask
   task automatic close_out();
      $display("counts: %0d compared, %0d mismatched", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // scoreboard: each read access takes the oldest note
   always @(posedge i_clock) begin
      // every access must finish at once and without error
      if (i_apb.psel && i_apb.penable) check("response", 32'h2, {30'h0, o_apb.pready, o_apb.pslverr});
      if (i_apb.psel && i_apb.penable && !i_apb.pwrite) begin
         check(name_q.pop_front(), exp_q.pop_front(), o_apb.prdata & care_q.pop_front());
      end
   end
   // hang guard, well above the few hundred cycles needed
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      void'($urandom(32'hbe80afb3));
      repeat (10) @(posedge i_clock);
      #1 i_rst_b = 1;
      for (int k = 0; k < 9; k++) begin
         stat[k] = (k == 0) ? OWN_RESET : '0;
         rd(addr(k, 2), st(k), '1, "reset status");
      end
      bus(1'b1, 12'h00c, '1);
      rd(12'h00c, '0, '1, "reserved");
      rd(12'h0ac, '0, '1, "reserved");
      rd(OFF_OE_EN, '0, '1, "write-only");
      $display("test reset done");
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 9; k++) begin
            d1 = $urandom;
            d2 = $urandom;
            bus(1'b1, addr(k, 0), d1);
            bus(1'b1, addr(k, 1), d2);
            stat[k] = (stat[k] | d1) & ~d2;
            rd(addr(k, 2), st(k), '1, "pair status");
         end
      end
      d1 = $urandom;
      bus(1'b1, OFF_LVL_STAT, d1);
      stat[3] = (stat[3] & ~stat[8]) | (d1 & stat[8]);
      rd(OFF_LVL_STAT, st(3), '1, "direct write");
      $display("test pairs done");
      bus(1'b1, OFF_OWN_EN, '1);
      bus(1'b1, OFF_OE_EN, '1);
      bus(1'b1, OFF_OD_DIS, '1);
      repeat (8) @(posedge i_clock);
      rd(OFF_PAD_RB, stat[3], '1, "pad driven");
      bus(1'b1, OFF_OE_DIS, '1);
      ext = $urandom;
      repeat (8) @(posedge i_clock);
      rd(OFF_PAD_RB, ext, '1, "pad input");
      // release lines 8 to 15 so only the pull-ups hold them high
      bus(1'b1, OFF_PU_EN, '1);
      ext_en = ~32'h0000ff00;
      repeat (8) @(posedge i_clock);
      rd(OFF_PAD_RB, ext | 32'h0000ff00, '1, "pad pulled up");
      ext_en = '1;
      // let the changes of the restored lines settle before the flush
      repeat (8) @(posedge i_clock);
      $display("test pads done");
      bus(1'b1, OFF_IRQ_DIS, '1);
      bus(1'b1, OFF_IRQ_EN, 32'h00000020);
      rd(OFF_IRQ_PEND, '0, '0, "pending flush");
      ext ^= 32'h00000060;
      repeat (10) @(posedge i_clock);
      check("irq raised", 32'h1, {31'h0, o_irq});
      rd(OFF_IRQ_PEND, 32'h00000060, '1, "pending");
      rd(OFF_IRQ_PEND, '0, '1, "pending cleared");
      repeat (3) @(posedge i_clock);
      check("irq dropped", 32'h0, {31'h0, o_irq});
      ext ^= 32'h00000040;
      repeat (10) @(posedge i_clock);
      check("irq masked", 32'h0, {31'h0, o_irq});
      rd(OFF_IRQ_PEND, 32'h00000040, '1, "unmasked pending");
      $display("test interrupt done");
      i_periph = {$urandom, $urandom, $urandom, $urandom};
      bus(1'b1, OFF_OWN_DIS, '1);
      sb = stat[7];
      d2 = (sb & i_periph.b_oe) | (~sb & i_periph.a_oe);
      d1 = (sb & i_periph.b_out) | (~sb & i_periph.a_out);
      repeat (8) @(posedge i_clock);
      rd(OFF_PAD_RB, (d2 & d1) | (~d2 & ext), '1, "pad by peripheral");
      $display("test peripheral done");
      close_out();
   end
endmodule // testbench
